// file: logic/adsc_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module adsc_top (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic [7:0]      rd_data,
	// core status
	input  wire logic       sleep_active,
	output logic            irq,
	output logic            wake,
	// analog front end
	input  wire logic       cmp_in,
	output logic [1:0]      chan_sel,
	output logic            sample_closed,
	output logic [9:0]      sar_code,
	output logic            conv_power,
	output logic            vref_ext_sel,
	// pin circuitry
	output logic [3:0]      digital_in_off,
	output logic [3:0]      pullup_off,
	output logic [3:0]      ioc_off
);
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_RECOVER} adsc_state_t;

	adsc_state_t            state_reg;
	adsc_pkg::adsc_ctrl_t   ctrl_reg;
	adsc_pkg::adsc_pinclk_t pinclk_reg;
	logic                   done_flag_reg;
	logic                   done_en_reg;
	logic [7:0]             res_high_reg;
	logic [7:0]             res_low_reg;
	logic [2:0]             cs_lat_reg;
	logic [15:0]            cyc_cnt_reg;
	logic [3:0]             tad_idx_reg;
	logic                   shutdown_reg;
	logic                   cmp_meta_reg;
	logic                   cmp_sync_reg;
	logic [9:0]             sar_acc_reg;
	logic [15:0]            tad_len;
	logic                   tad_tick;
	logic                   rc_sel_lat;
	logic                   rc_sel_now;
	logic                   ctrl_wr;
	logic                   start_req;
	logic                   abort_req;
	logic                   sleep_kill;
	logic                   conv_done;
	logic                   busy;
	logic [9:0]             final_code;
	logic [9:0]             sar_next;

	// conversion clock period in core cycles from latched select
	function automatic logic [15:0] tad_cycles(input logic [2:0] cs);
		logic [15:0] n;
		n = 16'h0002;
		if (cs[1:0] == 2'h3) begin
			n = 16'(adsc_pkg::RC_CYCLES);
		end else if (cs == adsc_pkg::CS_DIV2) begin
			n = 16'h0002;
		end else if (cs == adsc_pkg::CS_DIV4) begin
			n = 16'h0004;
		end else if (cs == adsc_pkg::CS_DIV8) begin
			n = 16'h0008;
		end else if (cs == adsc_pkg::CS_DIV16) begin
			n = 16'h0010;
		end else if (cs == adsc_pkg::CS_DIV32) begin
			n = 16'h0020;
		end else begin
			n = 16'h0040;
		end
		return n;
	endfunction : tad_cycles

	// request decode
	assign ctrl_wr    = wr_en && (addr == adsc_pkg::OFS_CTRL);
	assign rc_sel_now = (pinclk_reg.clk_sel[1:0] == 2'h3);
	assign rc_sel_lat = (cs_lat_reg[1:0] == 2'h3);
	assign busy       = (state_reg == ST_DELAY) || (state_reg == ST_CONV);
	// start needs the module already on, not turned on by the same write
	assign start_req  = ctrl_wr && wr_data[adsc_pkg::GO_BIT] && ctrl_reg.module_on && !shutdown_reg
		&& (state_reg == ST_IDLE);
	assign abort_req  = ctrl_wr && !wr_data[adsc_pkg::GO_BIT] && busy;
	assign sleep_kill = sleep_active && busy && !rc_sel_lat;
	assign tad_len    = tad_cycles(cs_lat_reg);
	assign tad_tick   = (cyc_cnt_reg == tad_len - 16'h0001);
	assign conv_done  = (state_reg == ST_CONV) && tad_tick
		&& (tad_idx_reg == 4'(adsc_pkg::TAD_PER_CONV - 1)) && !abort_req && !sleep_kill;
	assign final_code = {sar_acc_reg[9:1], cmp_sync_reg ? sar_acc_reg[0] : 1'b0};

	// comparator arrives from the analog side, two flops before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= cmp_in;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_req) begin
						state_reg <= (pinclk_reg.clk_sel[1:0] == 2'h3) ? ST_DELAY : ST_CONV;
					end
				end
				ST_DELAY: begin
					if (abort_req || !ctrl_reg.module_on) begin
						state_reg <= ST_IDLE;
					end else if (cyc_cnt_reg == 16'(adsc_pkg::INSTR_CYCLES - 1)) begin
						state_reg <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (sleep_kill || !ctrl_reg.module_on) begin
						state_reg <= ST_IDLE;
					end else if (abort_req) begin
						state_reg <= ST_RECOVER;
					end else if (conv_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					if (tad_tick && tad_idx_reg == 4'(adsc_pkg::TAD_RECOVER - 1)) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// cycle and conversion clock period counters
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt_reg <= 16'h0000;
			tad_idx_reg <= 4'h0;
		end else if (start_req || (state_reg == ST_DELAY && cyc_cnt_reg == 16'(adsc_pkg::INSTR_CYCLES - 1))
			|| abort_req || state_reg == ST_IDLE) begin
			cyc_cnt_reg <= 16'h0000;
			tad_idx_reg <= 4'h0;
		end else if (state_reg == ST_DELAY) begin
			cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
		end else if (tad_tick) begin
			cyc_cnt_reg <= 16'h0000;
			tad_idx_reg <= tad_idx_reg + 4'h1;
		end else begin
			cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
		end
	end

	// settings latched at start so mid-conversion writes cannot disturb it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_lat_reg <= adsc_pkg::RST_PIN_CLK[6:4];
			chan_sel   <= 2'h0;
		end else if (start_req) begin
			cs_lat_reg <= pinclk_reg.clk_sel;
			chan_sel   <= ctrl_reg.chan;
		end else if (state_reg == ST_IDLE) begin
			chan_sel   <= ctrl_reg.chan; // acquisition follows the selected channel
		end
	end

	// next trial: settle the bit under test, raise the one below it
	always_comb begin
		sar_next = sar_acc_reg;
		for (int b = 0; b < 10; b++) begin
			if (b == 10 - int'(tad_idx_reg)) begin
				sar_next[b] = cmp_sync_reg;
			end
			if (b == 9 - int'(tad_idx_reg)) begin
				sar_next[b] = 1'b1;
			end
		end
	end

	// successive approximation: first period holds, then one bit per period
	// the new trial leaves at once so the comparator sees it for a whole period;
	// the trial register and the two-flop synchroniser cost three core cycles, so the /2 setting cannot resolve bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sar_acc_reg <= 10'h000;
			sar_code    <= 10'h200;
		end else if (start_req) begin
			sar_acc_reg <= 10'h200;
			sar_code    <= 10'h200;
		end else if (state_reg == ST_CONV && tad_tick && tad_idx_reg != 4'h0) begin
			sar_acc_reg <= sar_next;
			sar_code    <= sar_next;
		end
	end

	// switch closed while the converter is powered and not converting; no discharge path exists
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_closed <= 1'b0;
		end else begin
			sample_closed <= conv_power && !busy;
		end
	end

	// result store has no reset so a device reset keeps the last value
	always_ff @(posedge core_clk) begin
		if (conv_done) begin
			if (ctrl_reg.right_just) begin
				res_high_reg <= {6'h00, final_code[9:8]};
				res_low_reg  <= final_code[7:0];
			end else begin
				res_high_reg <= final_code[9:2];
				res_low_reg  <= {final_code[1:0], 6'h00};
			end
		end
	end

	// control register; hardware clears busy by leaving the conversion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= adsc_pkg::RST_CTRL;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg.right_just <= wr_data[7];
				ctrl_reg.vref_ext   <= wr_data[6];
				ctrl_reg.chan       <= wr_data[3:2];
				ctrl_reg.module_on  <= wr_data[adsc_pkg::ON_BIT];
			end
			ctrl_reg.go     <= 1'b0; // readback comes from the sequencer
			ctrl_reg.unused <= 2'h0;
		end
	end

	// pin function and clock select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinclk_reg <= adsc_pkg::RST_PIN_CLK;
		end else if (wr_en && addr == adsc_pkg::OFS_PIN_CLK) begin
			pinclk_reg <= {1'b0, wr_data[6:0]};
		end
	end

	// analog pins lose digital input, pull-up and change detect
	assign digital_in_off = pinclk_reg.analog_pin_select;
	assign pullup_off     = pinclk_reg.analog_pin_select;
	assign ioc_off        = pinclk_reg.analog_pin_select;
	assign vref_ext_sel   = ctrl_reg.vref_ext;

	// done flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_flag_reg <= 1'b0;
			done_en_reg   <= 1'b0;
		end else begin
			if (conv_done) begin
				done_flag_reg <= 1'b1;
			end else if (wr_en && addr == adsc_pkg::OFS_IRQ_FLAGS) begin
				done_flag_reg <= wr_data[adsc_pkg::DONE_BIT];
			end
			if (wr_en && addr == adsc_pkg::OFS_IRQ_EN) begin
				done_en_reg <= wr_data[adsc_pkg::DONE_BIT];
			end
		end
	end

	// converter power drops in sleep without the RC clock or after a silent finish
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shutdown_reg <= 1'b0;
		end else if (!sleep_active) begin
			shutdown_reg <= 1'b0;
		end else if (!rc_sel_now && !busy) begin
			shutdown_reg <= 1'b1;
		end else if (sleep_kill) begin
			shutdown_reg <= 1'b1;
		end else if (conv_done && !done_en_reg) begin
			shutdown_reg <= 1'b1;
		end
	end

	// registered outputs toward the core and the analog side
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq        <= 1'b0;
			wake       <= 1'b0;
			conv_power <= 1'b0;
		end else begin
			irq        <= (done_flag_reg || conv_done) && done_en_reg;
			wake       <= sleep_active && conv_done && done_en_reg;
			conv_power <= ctrl_reg.module_on && !shutdown_reg && !sleep_kill;
		end
	end

	// read port, data in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (!rd_en) begin
			rd_data <= 8'h00;
		end else if (addr == adsc_pkg::OFS_IRQ_FLAGS) begin
			rd_data <= {1'b0, done_flag_reg, 6'h00};
		end else if (addr == adsc_pkg::OFS_IRQ_EN) begin
			rd_data <= {1'b0, done_en_reg, 6'h00};
		end else if (addr == adsc_pkg::OFS_CTRL) begin
			rd_data <= {ctrl_reg.right_just, ctrl_reg.vref_ext, 2'h0, ctrl_reg.chan, busy, ctrl_reg.module_on};
		end else if (addr == adsc_pkg::OFS_PIN_CLK) begin
			rd_data <= pinclk_reg;
		end else if (addr == adsc_pkg::OFS_RES_HIGH) begin
			rd_data <= res_high_reg;
		end else if (addr == adsc_pkg::OFS_RES_LOW) begin
			rd_data <= res_low_reg;
		end else begin
			rd_data <= 8'h00;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_done_sets_flag: assert property (conv_done |=> done_flag_reg)
		else $error("done flag not set after completion");
	a_done_clears_busy: assert property (conv_done |=> !busy)
		else $error("busy still set after completion");
	a_rc_start_delay: assert property (start_req && rc_sel_now
		|=> state_reg == ST_DELAY [*4] ##1 state_reg == ST_CONV)
		else $error("rc start not delayed one instruction");
	a_div_start_now: assert property (start_req && !rc_sel_now |=> state_reg == ST_CONV)
		else $error("divider start delayed");
	a_sleep_abort: assert property (sleep_kill |=> state_reg == ST_IDLE && ctrl_reg.module_on)
		else $error("sleep abort failed");
	a_abort_keeps_res: assert property (abort_req && state_reg == ST_CONV |=> $stable(res_high_reg) [*2])
		else $error("result changed on abort");
	a_cs_held: assert property (busy && !start_req |=> $stable(cs_lat_reg))
		else $error("latched clock select changed");
	a_pins_follow: assert property (wr_en && addr == adsc_pkg::OFS_PIN_CLK
		|=> digital_in_off == $past(wr_data[3:0]) && pullup_off == $past(wr_data[3:0])
		&& ioc_off == $past(wr_data[3:0]))
		else $error("pin disables differ from analog select");
	a_right_just: assert property (conv_done && ctrl_reg.right_just |=> res_high_reg[7:2] == 6'h00)
		else $error("right justified high bits nonzero");
	a_silent_off: assert property (conv_done && sleep_active && !done_en_reg |=> ##1 !conv_power)
		else $error("converter left on after silent sleep finish");
	a_wake_pulse: assert property (conv_done && sleep_active && done_en_reg |=> wake)
		else $error("no wake after sleep completion");
	a_conv_len: assert property (start_req && !rc_sel_now && pinclk_reg.clk_sel == adsc_pkg::CS_DIV2
		&& !sleep_active ##1 (!abort_req && ctrl_reg.module_on) [*8] |-> ##14 conv_done)
		else $error("conversion length wrong");

	c_conv_done: cover property (conv_done);
	c_abort: cover property (abort_req && state_reg == ST_CONV);
	c_sleep_wake: cover property (wake);
	c_sleep_kill: cover property (sleep_kill);
endmodule : adsc_top

// file: logic/adsc_pkg.sv
package adsc_pkg;
	// register addresses
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_RES_HIGH  = 8'h1E;
	localparam logic [7:0] OFS_CTRL      = 8'h1F;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h8C;
	localparam logic [7:0] OFS_RES_LOW   = 8'h9E;
	localparam logic [7:0] OFS_PIN_CLK   = 8'h9F;
	// field positions
	localparam int DONE_BIT = 6;
	localparam int GO_BIT   = 1;
	localparam int ON_BIT   = 0;
	// reset values
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_PIN_CLK = 8'h0F;
	// clock select codes
	localparam logic [2:0] CS_DIV2  = 3'h0;
	localparam logic [2:0] CS_DIV4  = 3'h4;
	localparam logic [2:0] CS_DIV8  = 3'h1;
	localparam logic [2:0] CS_DIV16 = 3'h5;
	localparam logic [2:0] CS_DIV32 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h6;
	// timing
	localparam int CLK_PERIOD_NS   = 25;
	localparam int RC_MAX_FREQ_KHZ = 500;
	localparam int RC_CYCLES       = (1000000 / RC_MAX_FREQ_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INSTR_CYCLES    = 4;
	localparam int TAD_PER_CONV    = 11;
	localparam int TAD_RECOVER     = 2;
	// control register layout
	typedef struct packed {
		logic       right_just;
		logic       vref_ext;
		logic [1:0] unused;
		logic [1:0] chan;
		logic       go;
		logic       module_on;
	} adsc_ctrl_t;
	// pin function and clock select layout
	typedef struct packed {
		logic       unused;
		logic [2:0] clk_sel;
		logic [3:0] analog_pin_select;
	} adsc_pinclk_t;
endpackage : adsc_pkg

// file: verification/adsc_analog_model.sv
`timescale 1ns/10ps
// analog sources and comparator on the far side of the converter
module adsc_analog_model (
	// held channel and trial code from the converter
	input  wire logic [1:0]  chan_sel,
	input  wire logic [9:0]  sar_code,
	// source levels, ten bits per channel
	input  wire logic [39:0] levels,
	// comparator verdict
	output logic             cmp_in
);
	// pins stay inputs so the sources alone set the voltage
	// comparator: input at or above the trial code keeps the bit
	always_comb begin
		cmp_in = (levels[chan_sel*10 +: 10] >= sar_code);
	end
endmodule : adsc_analog_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic       core_clk, rst_n, wr_en, rd_en, sleep_active, cmp_in;
	logic [7:0] addr, wr_data, rd_data, d;
	logic       irq, wake, sample_closed, conv_power, vref_ext_sel;
	logic [1:0] chan_sel;
	logic [9:0] sar_code;
	logic [3:0] digital_in_off, pullup_off, ioc_off;
	logic [39:0] levels;
	int         fail_count, tests_run, i;
	int         divs[8] = '{2, 4, 8, 16, 32, 64, 80, 80};
	logic [2:0] codes[8];

	adsc_top adsc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sleep_active(sleep_active), .irq(irq),
		.wake(wake), .cmp_in(cmp_in), .chan_sel(chan_sel), .sample_closed(sample_closed),
		.sar_code(sar_code), .conv_power(conv_power), .vref_ext_sel(vref_ext_sel),
		.digital_in_off(digital_in_off), .pullup_off(pullup_off), .ioc_off(ioc_off));
	adsc_analog_model adsc_analog_model_inst (.chan_sel(chan_sel), .sar_code(sar_code),
		.levels(levels), .cmp_in(cmp_in));

	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic conclude;
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp8

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		addr    <= a;
		wr_data <= v;
		wr_en   <= 1'b1;
		@(posedge core_clk);
		wr_en   <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	task automatic wait_idle;
		for (int k = 0; k < 600; k++) begin
			rd(adsc_pkg::OFS_CTRL, d);
			if (d[adsc_pkg::GO_BIT] === 1'b0)
				break;
		end
	endtask : wait_idle

	// settling after a channel change, well above the acquisition time
	task automatic acquire;
		repeat (40) @(posedge core_clk);
	endtask : acquire

	// watchdog sized well above the sum of all conversions
	initial begin
		#(25 * 40000);
		fail_count++;
		conclude();
	end

	initial begin
		codes = '{adsc_pkg::CS_DIV2, adsc_pkg::CS_DIV4, adsc_pkg::CS_DIV8, adsc_pkg::CS_DIV16,
			adsc_pkg::CS_DIV32, adsc_pkg::CS_DIV64, 3'h3, 3'h7};
		levels = {10'h333, 10'h2A5, 10'h1C3, 10'h0F0};
		{wr_en, rd_en, sleep_active} = '0;
		addr = 8'h00;
		wr_data = 8'h00;
		fail_count = 0;
		tests_run = 0;
		rst_n = 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(adsc_pkg::OFS_CTRL, d);    cmp8("ctrl", adsc_pkg::RST_CTRL, d);
		rd(adsc_pkg::OFS_PIN_CLK, d); cmp8("pinclk", adsc_pkg::RST_PIN_CLK, d);
		rd(8'h55, d);                 cmp8("unmapped", 8'h00, d);
		cmp8("din_off", 8'h0F, {4'h0, digital_in_off});
		wr(adsc_pkg::OFS_PIN_CLK, {1'b0, adsc_pkg::CS_DIV2, 4'h5});
		@(posedge core_clk);
		#1 cmp8("din_off", 8'h05, {4'h0, digital_in_off});
		cmp8("pull_off", 8'h05, {4'h0, pullup_off});
		cmp8("ioc_off", 8'h05, {4'h0, ioc_off});
		// every clock code: busy until eleven periods, idle shortly after
		wr(adsc_pkg::OFS_CTRL, 8'h89);
		acquire();
		for (i = 0; i < 8; i++) begin
			wr(adsc_pkg::OFS_PIN_CLK, {1'b0, codes[i], 4'h5});
			wr(adsc_pkg::OFS_CTRL, 8'h8B);
			repeat (11 * divs[i] + (i > 5 ? 4 : 0) - 6) @(posedge core_clk);
			rd(adsc_pkg::OFS_CTRL, d); cmp8("busy", 8'h8B, d);
			repeat (14) @(posedge core_clk);
			rd(adsc_pkg::OFS_CTRL, d); cmp8("idle", 8'h89, d);
		end
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'h02, d);
		rd(adsc_pkg::OFS_RES_LOW, d);  cmp8("res_lo", 8'hA5, d);
		rd(adsc_pkg::OFS_IRQ_FLAGS, d); cmp8("flags", 8'h40, d);
		// left justified on channel 1, external reference; /8 leaves the synchroniser time
		wr(adsc_pkg::OFS_PIN_CLK, {1'b0, adsc_pkg::CS_DIV8, 4'h5});
		wr(adsc_pkg::OFS_CTRL, 8'h45);
		acquire();
		#1 cmp8("vref", 8'h01, {7'h0, vref_ext_sel});
		cmp8("sample", 8'h01, {7'h0, sample_closed});
		wr(adsc_pkg::OFS_CTRL, 8'h47);
		wait_idle();
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'h70, d);
		rd(adsc_pkg::OFS_RES_LOW, d);  cmp8("res_lo", 8'hC0, d);
		// abort in mid conversion keeps the previous result
		wr(adsc_pkg::OFS_PIN_CLK, {1'b0, adsc_pkg::CS_DIV64, 4'h5});
		wr(adsc_pkg::OFS_CTRL, 8'h0D);
		acquire();
		wr(adsc_pkg::OFS_CTRL, 8'h0F);
		repeat (50) @(posedge core_clk);
		#1 cmp8("sample", 8'h00, {7'h0, sample_closed});
		wr(adsc_pkg::OFS_CTRL, 8'h0D);
		repeat (2 * 64 + 10) @(posedge core_clk);
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'h70, d);
		// interrupt raised by enable, dropped by clearing the flag
		wr(adsc_pkg::OFS_IRQ_EN, 8'h40);
		repeat (2) @(posedge core_clk);
		#1 cmp8("irq", 8'h01, {7'h0, irq});
		wr(adsc_pkg::OFS_IRQ_FLAGS, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 cmp8("irq", 8'h00, {7'h0, irq});
		// sleep with a divider clock aborts and powers down
		wr(adsc_pkg::OFS_CTRL, 8'h0F);
		repeat (50) @(posedge core_clk);
		sleep_active <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1 cmp8("power", 8'h00, {7'h0, conv_power});
		rd(adsc_pkg::OFS_CTRL, d); cmp8("ctrl", 8'h0D, d);
		sleep_active <= 1'b0;
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'h70, d);
		// RC clock converts through sleep and wakes the core
		wr(adsc_pkg::OFS_PIN_CLK, {1'b0, 3'h3, 4'h5});
		acquire();
		wr(adsc_pkg::OFS_CTRL, 8'h0F);
		sleep_active <= 1'b1;
		for (i = 0; i < 1500; i++) begin
			@(posedge core_clk);
			#1;
			if (wake === 1'b1)
				break;
		end
		cmp8("wake", 8'h01, {7'h0, wake});
		sleep_active <= 1'b0;
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'hCC, d);
		rd(adsc_pkg::OFS_CTRL, d);     cmp8("ctrl", 8'h0D, d);
		// without the enable the converter shuts off but stays on in software
		wr(adsc_pkg::OFS_IRQ_EN, 8'h00);
		wr(adsc_pkg::OFS_CTRL, 8'h0F);
		sleep_active <= 1'b1;
		repeat (11 * 80 + 30) @(posedge core_clk);
		#1 cmp8("power", 8'h00, {7'h0, conv_power});
		sleep_active <= 1'b0;
		rd(adsc_pkg::OFS_CTRL, d); cmp8("ctrl", 8'h0D, d);
		// reset mid conversion keeps the result registers
		wr(adsc_pkg::OFS_PIN_CLK, {1'b0, adsc_pkg::CS_DIV64, 4'h5});
		wr(adsc_pkg::OFS_CTRL, 8'h0B);
		repeat (30) @(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(adsc_pkg::OFS_RES_HIGH, d); cmp8("res_hi", 8'hCC, d);
		rd(adsc_pkg::OFS_CTRL, d);     cmp8("ctrl", adsc_pkg::RST_CTRL, d);
		cmp8("power", 8'h00, {7'h0, conv_power});
		conclude();
	end
endmodule : tb_top
